// [logic/pao_defines.svh]
// Constants for the port A pin override block.
// Assumes inclusion by bare name from the package and the design.
`ifndef PAO_DEFINES_SVH
`define PAO_DEFINES_SVH

// ------------------------------------------------------------
// Port geometry
// ------------------------------------------------------------
`define PAO_PINS 8
`define PAO_ZERO8 8'h00

// ------------------------------------------------------------
// Pin positions of the claimed functions
// ------------------------------------------------------------
`define PAO_PIN_REF 7
`define PAO_PIN_SEL 6
`define PAO_PIN_SCK 5
`define PAO_PIN_MOSI 4
`define PAO_PIN_MISO 2
`define PAO_PIN_TX 1

// ------------------------------------------------------------
// Control register layout and reset values
// ------------------------------------------------------------
`define PAO_GLOBAL_PUD_BIT 4
`define PAO_PUD_A_BIT 0
`define PAO_PUD_B_BIT 1
`define PAO_CTRL_RESET 8'h00
`define PAO_PORTCR_RESET 8'h00

`endif

// [logic/pao_pkg.sv]
// Types shared by the port A pin override block.
// Assumes pao_defines.svh on the include path.
`include "pao_defines.svh"

package pao_pkg;

  // ------------------------------------------------------------
  // Per-pin override bundle
  // ------------------------------------------------------------
  typedef struct packed {
    logic [`PAO_PINS-1:0] ddoe;
    logic [`PAO_PINS-1:0] ddov;
    logic [`PAO_PINS-1:0] pvoe;
    logic [`PAO_PINS-1:0] pvov;
    logic [`PAO_PINS-1:0] puoe;
    logic [`PAO_PINS-1:0] puov;
  } pao_override_type;

  // ------------------------------------------------------------
  // Complete state of the block
  // ------------------------------------------------------------
  typedef struct packed {
    logic [`PAO_PINS-1:0] pad_out;
    logic [`PAO_PINS-1:0] pad_oe;
    logic [`PAO_PINS-1:0] pullup_en;
    logic [`PAO_PINS-1:0] sync1;
    logic [`PAO_PINS-1:0] sync2;
    logic port_a_pud;
    logic port_b_pud;
    logic global_pud;
  } pao_state_type;

endpackage : pao_pkg

// [logic/pao_port_a_override.sv]
// Pin override logic for the eight pins of port A.
// Assumes peripheral controls arrive on core_clk; pad inputs are async.
`timescale 1ns/1ps
`include "pao_defines.svh"

module pao_port_a_override (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Port registers
  input wire logic [7:0] pin_direction_bit,
  input wire logic [7:0] pin_output_latch_bit,
  // Control register writes
  input wire logic mcu_control_wr,
  input wire logic [7:0] mcu_control_reg,
  input wire logic port_control_wr,
  input wire logic [7:0] port_control_reg,
  // SPI
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic spi_sck_out,
  input wire logic spi_mosi_out,
  input wire logic spi_miso_out,
  // Three-wire serial, timer, transmitters
  input wire logic usi_three_wire_mode,
  input wire logic usi_serial_data_out,
  input wire logic timer0_compare_a_enable,
  input wire logic timer0_compare_a_out,
  input wire logic uart_tx_enable,
  input wire logic uart_tx,
  input wire logic lin_enable,
  input wire logic lin_tx,
  // Reference
  input wire logic ref_output_enable,
  input wire logic ref_internal_selected,
  input wire logic external_ref_input,
  // Pads
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pullup_en,
  // Status
  output logic [7:0] pin_change_source,
  output logic port_a_pullup_disable,
  output logic port_b_pullup_disable,
  output logic global_pullup_disable,
  output logic port_b_pud_effective
);

  // ------------------------------------------------------------
  // State and override terms
  // ------------------------------------------------------------
  pao_pkg::pao_state_type state_q;
  pao_pkg::pao_state_type state_d;
  pao_pkg::pao_override_type ovr;
  logic spi_slave;
  logic spi_mst;
  logic pud_a_eff;
  logic ref_out_active;
  logic pin7_analog;
  logic tx_claim;
  logic usi_do_claim;
  logic oc_claim;

  // Mode decode of the claiming peripherals
  assign spi_slave = spi_enable & ~spi_master;
  assign spi_mst = spi_enable & spi_master;
  assign ref_out_active = ref_output_enable & ref_internal_selected;
  assign pin7_analog = ref_out_active | external_ref_input;
  assign tx_claim = uart_tx_enable | lin_enable;
  assign usi_do_claim = usi_three_wire_mode;
  assign oc_claim = timer0_compare_a_enable;

  // Port-wise disable ORed with the global one
  assign pud_a_eff = state_q.port_a_pud | state_q.global_pud;

  // ------------------------------------------------------------
  // Per-pin override generation
  // ------------------------------------------------------------
  for (genvar i = 0; i < `PAO_PINS; i++) begin : g_pin
    logic forced_in;
    logic forced_out;
    logic val_ovr;
    logic val_bit;
    logic pu_forced_off;
    // Forced inputs per pin and mode
    if (i == `PAO_PIN_SEL || i == `PAO_PIN_SCK || i == `PAO_PIN_MOSI) begin : g_slave_in
      assign forced_in = spi_slave;
    end else if (i == `PAO_PIN_MISO) begin : g_master_in
      assign forced_in = spi_mst;
    end else if (i == `PAO_PIN_REF) begin : g_ref_in
      assign forced_in = pin7_analog;
    end else begin : g_no_in
      assign forced_in = 1'b0;
    end
    // Forced outputs
    if (i == `PAO_PIN_TX) begin : g_tx_out
      assign forced_out = tx_claim;
    end else begin : g_no_out
      assign forced_out = 1'b0;
    end
    // Value overrides; the direction bit decides the driver except on pin 1 (transmitters force output) and pins 2, 4-6, 7 (SPI or reference forces input)
    if (i == `PAO_PIN_SCK) begin : g_sck_val
      assign val_ovr = spi_mst;
      assign val_bit = spi_sck_out;
    end else if (i == `PAO_PIN_MOSI) begin : g_mosi_val
      assign val_ovr = spi_mst;
      assign val_bit = spi_mosi_out;
    end else if (i == `PAO_PIN_MISO) begin : g_miso_val
      // SPI slave data wins over three-wire data, which wins over the timer
      assign val_ovr = spi_slave | usi_do_claim | oc_claim;
      assign val_bit = spi_slave ? spi_miso_out :
                       usi_do_claim ? usi_serial_data_out : timer0_compare_a_out;
    end else if (i == `PAO_PIN_TX) begin : g_tx_val
      assign val_ovr = tx_claim;
      assign val_bit = lin_enable ? lin_tx : uart_tx;
    end else begin : g_no_val
      assign val_ovr = 1'b0;
      assign val_bit = 1'b0;
    end
    // Pull-up hard off for analog reference and transmitter pins
    assign pu_forced_off = (i == `PAO_PIN_REF) ? pin7_analog :
                           (i == `PAO_PIN_TX) ? tx_claim : 1'b0;
    assign ovr.ddoe[i] = forced_in | forced_out;
    assign ovr.ddov[i] = forced_out;
    assign ovr.pvoe[i] = val_ovr;
    assign ovr.pvov[i] = val_bit;
    assign ovr.puoe[i] = forced_in | pu_forced_off;
    // Forced input keeps latch pull-up control, still under the disables
    assign ovr.puov[i] = ~pu_forced_off & pin_output_latch_bit[i] & ~pud_a_eff;
  end : g_pin

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // Control bits load on their write strobes
    if (mcu_control_wr) begin
      state_d.global_pud = mcu_control_reg[`PAO_GLOBAL_PUD_BIT];
    end
    if (port_control_wr) begin
      state_d.port_a_pud = port_control_reg[`PAO_PUD_A_BIT];
      state_d.port_b_pud = port_control_reg[`PAO_PUD_B_BIT];
    end
    // Driver enable, value and pull-up resolution
    state_d.pad_oe = (ovr.ddoe & ovr.ddov) | (~ovr.ddoe & pin_direction_bit);
    state_d.pad_out = (ovr.pvoe & ovr.pvov) | (~ovr.pvoe & pin_output_latch_bit);
    state_d.pullup_en = (ovr.puoe & ovr.puov) |
                        (~ovr.puoe & ~pin_direction_bit & pin_output_latch_bit &
                         {`PAO_PINS{~pud_a_eff}});
    // Pad synchroniser; only the second stage is observed
    state_d.sync1 = pad_in;
    state_d.sync2 = state_q.sync1;
    if (reset) begin
      state_d.pad_out = `PAO_ZERO8;
      state_d.pad_oe = `PAO_ZERO8;
      state_d.pullup_en = `PAO_ZERO8;
      state_d.sync1 = `PAO_ZERO8;
      state_d.sync2 = `PAO_ZERO8;
      state_d.global_pud = 1'(`PAO_CTRL_RESET >> `PAO_GLOBAL_PUD_BIT);
      state_d.port_a_pud = 1'(`PAO_PORTCR_RESET >> `PAO_PUD_A_BIT);
      state_d.port_b_pud = 1'(`PAO_PORTCR_RESET >> `PAO_PUD_B_BIT);
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    state_q <= state_d;
  end

  // ------------------------------------------------------------
  // Outputs, all from flip-flops except port_b_pud_effective, an OR of two
  // ------------------------------------------------------------
  assign pad_out = state_q.pad_out;
  assign pad_oe = state_q.pad_oe;
  assign pullup_en = state_q.pullup_en;
  assign pin_change_source = state_q.sync2;
  assign port_a_pullup_disable = state_q.port_a_pud;
  assign port_b_pullup_disable = state_q.port_b_pud;
  assign global_pullup_disable = state_q.global_pud;
  // Port B shares the global disable; its pins live elsewhere
  assign port_b_pud_effective = state_q.port_b_pud | state_q.global_pud;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_pud_port_off;
    @(posedge core_clk) disable iff (reset)
      $past(state_q.port_a_pud) && !$past(reset) |-> pullup_en == `PAO_ZERO8;
  endproperty
  a_pud_port_off: assert property (p_pud_port_off)
    else $error("pull-up on while port disable set");

  property p_pud_b_or;
    @(posedge core_clk) disable iff (reset)
      port_control_wr && !mcu_control_wr |=> port_b_pud_effective ==
        ($past(port_control_reg[`PAO_PUD_B_BIT]) | global_pullup_disable);
  endproperty
  a_pud_b_or: assert property (p_pud_b_or)
    else $error("port B effective disable is not the OR");

  property p_pin_change;
    @(posedge core_clk) disable iff (reset)
      ##2 !$past(reset, 2) |-> pin_change_source == $past(pad_in, 2);
  endproperty
  a_pin_change: assert property (p_pin_change)
    else $error("pin change source not two cycles behind pad");

  property p_ref_off;
    @(posedge core_clk) disable iff (reset)
      (ref_output_enable && ref_internal_selected) ##1 !$past(reset)
        |-> !pad_oe[`PAO_PIN_REF] && !pullup_en[`PAO_PIN_REF];
  endproperty
  a_ref_off: assert property (p_ref_off)
    else $error("pin 7 driven or pulled while reference out");

  property p_ext_ref_off;
    @(posedge core_clk) disable iff (reset)
      external_ref_input |=> !pad_oe[`PAO_PIN_REF] && !pullup_en[`PAO_PIN_REF];
  endproperty
  a_ext_ref_off: assert property (p_ext_ref_off)
    else $error("pin 7 driven or pulled while reference in");

  property p_slave_inputs;
    @(posedge core_clk) disable iff (reset)
      (spi_enable && !spi_master) |=> !pad_oe[`PAO_PIN_SEL] && !pad_oe[`PAO_PIN_SCK]
        && !pad_oe[`PAO_PIN_MOSI];
  endproperty
  a_slave_inputs: assert property (p_slave_inputs)
    else $error("SPI slave pin not forced to input");

  property p_slave_pull;
    @(posedge core_clk) disable iff (reset)
      (spi_enable && !spi_master && pin_output_latch_bit[`PAO_PIN_SEL] && !pud_a_eff
        && !mcu_control_wr && !port_control_wr) |=> pullup_en[`PAO_PIN_SEL];
  endproperty
  a_slave_pull: assert property (p_slave_pull)
    else $error("forced input lost latch pull-up");

  property p_master_sel_dir;
    @(posedge core_clk) disable iff (reset)
      spi_mst |=> pad_oe[`PAO_PIN_SEL] == $past(pin_direction_bit[`PAO_PIN_SEL]);
  endproperty
  a_master_sel_dir: assert property (p_master_sel_dir)
    else $error("master select pin ignores direction bit");

  property p_sck_master;
    @(posedge core_clk) disable iff (reset)
      (spi_enable && spi_master) |=> pad_out[`PAO_PIN_SCK] == $past(spi_sck_out);
  endproperty
  a_sck_master: assert property (p_sck_master)
    else $error("master clock not on pin 5");

  property p_mosi_master;
    @(posedge core_clk) disable iff (reset)
      (spi_enable && spi_master) |=> pad_out[`PAO_PIN_MOSI] == $past(spi_mosi_out);
  endproperty
  a_mosi_master: assert property (p_mosi_master)
    else $error("master data not on pin 4");

  property p_usi_do;
    @(posedge core_clk) disable iff (reset)
      (usi_three_wire_mode && !spi_enable) |=>
        pad_out[`PAO_PIN_MISO] == $past(usi_serial_data_out);
  endproperty
  a_usi_do: assert property (p_usi_do)
    else $error("three-wire data not on pin 2");

  property p_miso_master_in;
    @(posedge core_clk) disable iff (reset)
      (spi_enable && spi_master) |=> !pad_oe[`PAO_PIN_MISO];
  endproperty
  a_miso_master_in: assert property (p_miso_master_in)
    else $error("pin 2 driven in SPI master mode");

  property p_tx_out;
    @(posedge core_clk) disable iff (reset)
      (uart_tx_enable || lin_enable) |=> pad_oe[`PAO_PIN_TX] && !pullup_en[`PAO_PIN_TX];
  endproperty
  a_tx_out: assert property (p_tx_out)
    else $error("pin 1 not forced to output");

  property p_lin_val;
    @(posedge core_clk) disable iff (reset)
      lin_enable |=> pad_out[`PAO_PIN_TX] == $past(lin_tx);
  endproperty
  a_lin_val: assert property (p_lin_val)
    else $error("network transmit not on pin 1");

  property p_global_off;
    @(posedge core_clk) disable iff (reset)
      global_pullup_disable && !$past(mcu_control_wr) |-> pullup_en == `PAO_ZERO8;
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("pull-up on under global disable");

  property p_plain_pull;
    @(posedge core_clk) disable iff (reset)
      (!spi_enable && !tx_claim && !pin7_analog && !pud_a_eff && !mcu_control_wr
        && !port_control_wr) |=> pullup_en == $past(~pin_direction_bit & pin_output_latch_bit);
  endproperty
  a_plain_pull: assert property (p_plain_pull)
    else $error("plain pull-up mismatch");

  property p_reset_zero;
    @(posedge core_clk) reset |=> !global_pullup_disable && !port_a_pullup_disable
      && !port_b_pullup_disable && pad_oe == `PAO_ZERO8;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("disable bits not cleared by reset");

  // Main scenarios
  c_spi_slave: cover property (@(posedge core_clk) disable iff (reset) spi_enable && !spi_master);
  c_lin_tx: cover property (@(posedge core_clk) disable iff (reset) lin_enable ##1 lin_tx);
  c_ref_out: cover property (@(posedge core_clk) disable iff (reset) ref_out_active);
  c_global: cover property (@(posedge core_clk) disable iff (reset) global_pullup_disable);

endmodule : pao_port_a_override

// [tb/pao_pad_model.sv]
// Pad model for the eight port A pins: external drivers, pull-ups, floating.
// Assumes the block's pad_out, pad_oe and pullup_en ports on core_clk.
`timescale 1ns/1ps

module pao_pad_model (
  // Clock
  input wire logic core_clk,
  // Block side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pullup_en,
  // Far side drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Resolved pad levels
  output logic [7:0] pad_in
);
  // ------------------------------------------------------------
  // Floating level
  // ------------------------------------------------------------
  // Undriven pins toggle, so no stale value passes for a real one
  logic [7:0] float_q = 8'h55;
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end

  // ------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------
  // Block driver first, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pullup_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = float_q[i];
    end
  end
endmodule : pao_pad_model

// [tb/tb_top.sv]
// Self-checking bench for the port A pin override block.
// Assumes the pad model in tb/ and the design files under logic/.
`timescale 1ns/1ps

module tb_top;
  // Clock, reset and block inputs
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] dir = 8'h00, lat = 8'h00, mcr = 8'h00, pcr = 8'h00;
  logic [7:0] ext_v = 8'h00, ext_e = 8'h00;
  logic mwr = 1'b0, pwr = 1'b0, spe = 1'b0, spm = 1'b0, sck = 1'b0, mosi = 1'b0;
  logic miso = 1'b0, universal_serial_iface = 1'b0, usid = 1'b0, tce = 1'b0, tco = 1'b0, ute = 1'b0;
  logic utx = 1'b0, lne = 1'b0, ltx = 1'b0, roe = 1'b0, rsel = 1'b0, internal_ref_output = 1'b0;
  // Block outputs
  logic [7:0] pout, poe, pup, pcs, pin;
  logic pa, pb, pg, pbe;
  int failures = 0;
  int checks_done = 0;

  always #4 core_clk = ~core_clk;

  pao_port_a_override u_pao_port_a_override (.core_clk(core_clk), .reset(reset),
    .pin_direction_bit(dir), .pin_output_latch_bit(lat), .mcu_control_wr(mwr),
    .mcu_control_reg(mcr), .port_control_wr(pwr), .port_control_reg(pcr),
    .spi_enable(spe), .spi_master(spm), .spi_sck_out(sck), .spi_mosi_out(mosi),
    .spi_miso_out(miso), .usi_three_wire_mode(universal_serial_iface), .usi_serial_data_out(usid),
    .timer0_compare_a_enable(tce), .timer0_compare_a_out(tco), .uart_tx_enable(ute),
    .uart_tx(utx), .lin_enable(lne), .lin_tx(ltx), .ref_output_enable(roe),
    .ref_internal_selected(rsel), .external_ref_input(internal_ref_output), .pad_in(pin),
    .pad_out(pout), .pad_oe(poe), .pullup_en(pup), .pin_change_source(pcs),
    .port_a_pullup_disable(pa), .port_b_pullup_disable(pb),
    .global_pullup_disable(pg), .port_b_pud_effective(pbe));

  pao_pad_model u_pao_pad_model (.core_clk(core_clk), .pad_out(pout), .pad_oe(poe),
    .pullup_en(pup), .ext_val(ext_v), .ext_en(ext_e), .pad_in(pin));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Outputs are registered, so one edge passes before looking
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Control writes; pull-ups follow one edge after the stored bit
  task automatic wr_ctl(input logic to_port, input logic [7:0] v);
    if (to_port) begin
      pwr = 1'b1;
      pcr = v;
    end else begin
      mwr = 1'b1;
      mcr = v;
    end
    cyc(1);
    pwr = 1'b0;
    mwr = 1'b0;
    cyc(1);
  endtask : wr_ctl

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // Watchdog: the tests need a few hundred cycles at most
  initial begin
    #40000;
    failures++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(2);
    chk({pa, pb, pg, pbe, 4'h0}, 8'h00);
    chk(poe | pup | pout | pcs, 8'h00);
    reset = 1'b0;
    dir = 8'h0f;
    lat = 8'hff;
    cyc(1);
    chk(pup, 8'hf0);
    chk(poe, 8'h0f);
    chk(pout & poe, 8'h0f);
    $display("Test plain pull-ups done");

    wr_ctl(1'b1, 8'h01);
    chk({4'h0, pa, pb, pg, pbe}, 8'h08);
    chk(pup, 8'h00);
    wr_ctl(1'b1, 8'h02);
    chk({4'h0, pa, pb, pg, pbe}, 8'h05);
    chk(pup, 8'hf0);
    wr_ctl(1'b0, 8'hef);
    chk({6'h00, pg, pbe}, 8'h01);
    chk(pup, 8'hf0);
    wr_ctl(1'b0, 8'h10);
    chk({6'h00, pg, pbe}, 8'h03);
    chk(pup, 8'h00);
    wr_ctl(1'b1, 8'h00);
    chk({5'h00, pa, pb, pbe}, 8'h01);
    chk(pup, 8'h00);
    wr_ctl(1'b0, 8'h00);
    chk(pup, 8'hf0);
    $display("Test pull-up disables done");

    // SPI slave with the select pin pulled low by the far master
    ext_e = 8'h40;
    ext_v = 8'h00;
    spe = 1'b1;
    spm = 1'b0;
    dir = 8'hff;
    lat = 8'h70;
    for (int m = 0; m < 2; m++) begin
      miso = m[0];
      cyc(1);
      chk(poe, 8'h8f);
      chk(pup, 8'h70);
      chk({7'h00, pout[2]}, {7'h00, m[0]});
    end
    wr_ctl(1'b1, 8'h01);
    chk(pup, 8'h00);
    wr_ctl(1'b1, 8'h00);
    spm = 1'b1;
    dir = 8'h54;
    lat = 8'h04;
    cyc(1);
    chk(poe & 8'h74, 8'h50);
    chk(pup & 8'h04, 8'h04);
    spe = 1'b0;
    spm = 1'b0;
    ext_e = 8'h00;
    $display("Test SPI done");

    // Three-wire data and timer compare on pin 2
    universal_serial_iface = 1'b1;
    dir = 8'h04;
    lat = 8'h00;
    for (int m = 0; m < 2; m++) begin
      usid = m[0];
      cyc(1);
      chk(poe & 8'h14, 8'h04);
      chk({7'h00, pout[2]}, {7'h00, m[0]});
    end
    dir = 8'h00;
    lat = 8'h04;
    cyc(1);
    chk(poe & 8'h04, 8'h00);
    chk(pup & 8'h04, 8'h04);
    universal_serial_iface = 1'b0;
    tce = 1'b1;
    dir = 8'h04;
    lat = 8'h00;
    for (int m = 0; m < 2; m++) begin
      tco = m[0];
      cyc(1);
      chk({7'h00, pout[2]}, {7'h00, m[0]});
    end
    dir = 8'h00;
    cyc(1);
    chk(poe & 8'h04, 8'h00);
    tce = 1'b0;
    $display("Test pin 2 sources done");

    // Transmitters on pin 1, direction bit kept at input with latch one
    dir = 8'h00;
    lat = 8'h02;
    for (int m = 0; m < 4; m++) begin
      ute = 1'b1;
      lne = m[1];
      utx = m[0];
      ltx = ~m[0];
      cyc(1);
      chk(poe & 8'h02, 8'h02);
      chk(pup & 8'h02, 8'h00);
      chk({7'h00, pout[1]}, {7'h00, m[1] ? ~m[0] : m[0]});
    end
    ute = 1'b0;
    ltx = 1'b1;
    cyc(1);
    chk(poe & pout & 8'h02, 8'h02);
    lne = 1'b0;
    $display("Test pin 1 transmitters done");

    // Reference use of pin 7
    dir = 8'h80;
    lat = 8'h80;
    roe = 1'b1;
    rsel = 1'b0;
    cyc(1);
    chk(poe & 8'h80, 8'h80);
    rsel = 1'b1;
    cyc(1);
    chk((poe | pup) & 8'h80, 8'h00);
    roe = 1'b0;
    rsel = 1'b0;
    dir = 8'h00;
    internal_ref_output = 1'b1;
    cyc(1);
    chk((poe | pup) & 8'h80, 8'h00);
    internal_ref_output = 1'b0;
    cyc(1);
    chk(pup & 8'h80, 8'h80);
    $display("Test reference pin done");

    // Pin change sources follow the pads after two flops
    ext_e = 8'hff;
    ext_v = 8'ha5;
    cyc(3);
    chk(pcs, 8'ha5);
    ext_v = 8'h5a;
    cyc(3);
    chk(pcs, 8'h5a);
    $display("Test pin change sources done");

    // Second reset in mid-run clears the disables again
    wr_ctl(1'b1, 8'h03);
    reset = 1'b1;
    cyc(2);
    chk({pa, pb, pg, pbe, 4'h0}, 8'h00);
    // After release the pull-ups follow direction and latch again
    reset = 1'b0;
    cyc(1);
    chk(pup, 8'h80);
    $display("Test second reset done");
    end_of_test();
  end
endmodule : tb_top
